//--- ecc_config_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "ecc_regs.svh"

// Notes on behaviour
// [RQ1] The EEPROM is reached as an I2C master with one address byte over 64 bytes.
// [RQ2] The 16-bit checksum covers bytes 0x00 to 0x20 and 0x30 to 0x3F only.
// [RQ3] The 16-bit checksum uses x^16+x^12+x^5+1 from 1, low byte at 0x21, high at 0x22.
// [RQ4] Bytes 0x23 to 0x2E have their own 8-bit checksum.
// [RQ5] The 8-bit checksum uses x^8+x^7+x^4+x^2+x+1 from 1 and sits at 0x2F.
// [RQ6] Writing the configuration computes and stores both checksums.
// [RQ7] The register port can neither read nor write any checksum byte.
// [RQ8] Both checksums are checked at startup.
// [RQ9] Checks repeat cyclically unless the disable bit 6 of register 0x0D is set.
// [RQ10] A verify command triggers an explicit checksum check.
// [RQ11] A failed check sets the checksum error flag.
// [RQ12] A failed startup read restarts, and the third failure loads defaults.
// [RQ13] The converter starts only if startup saw no checksum, EEPROM or multiturn error.
// [RQ14] Bytes feed the checksums in address order, MSB first, compared after the last.
module ecc_config_checker
  import ecc_pkg::*;
#(
  parameter int QTR_CYCLES = 125,
  parameter int WRITE_WAIT_CYCLES = 500000,
  parameter int CYCLE_PERIOD = 10000000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // EEPROM link, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Commands and straps
  input wire logic verify_checksum_command,
  input wire logic write_config_command,
  input wire logic status_clear,
  input wire logic multiturn_error,
  input wire logic mode_strap,
  // Status
  output logic busy,
  output logic checksum_error,
  output logic eeprom_error,
  output logic startup_done,
  output logic converter_enable
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] mem [0:63];
  ecc_mode_type mode_reg;
  ecc_step_type step_reg;
  ecc_op_type op_reg;
  ecc_op_type cur_op;
  ecc_phase_type ph_reg;
  logic [5:0] addr_reg;
  logic [1:0] tries_reg;
  logic [3:0] bit_reg;
  logic [8:0] sh_reg;
  logic [15:0] config_checksum_word_reg, stored16_reg;
  logic [7:0] preset_checksum_byte_reg, stored8_reg, rdata_reg;
  logic [31:0] qcnt_reg, wait_reg, cyc_reg;
  logic startup_reg, verify_reg, fail_reg, bad_reg, eng_busy_reg, op_err_reg;
  logic scl_drv_reg, sda_drv_reg, pend_reg, strap_reg, crc_err_reg, eep_err_reg;
  logic done_reg, conv_reg;

  function automatic logic [15:0] config_checksum_word_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin // RQ14
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `ECC_POLY16) : {r[14:0], 1'b0}; // RQ3
    end
    return r;
  endfunction

  function automatic logic [7:0] preset_checksum_byte_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin // RQ14
      r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ `ECC_POLY8) : {r[6:0], 1'b0}; // RQ5
    end
    return r;
  endfunction

  function automatic logic is_hidden(input logic [5:0] a);
    return a == `ECC_C16_LO || a == `ECC_C16_HI || a == `ECC_C8_ADR;
  endfunction

  function automatic logic [7:0] dflt_byte(input logic [5:0] a, input logic strap);
    if (a < `ECC_DFLT_BEG || a > `ECC_DFLT_END || (strap && a == `ECC_DFLT_STRAP)) begin
      return '0;
    end
    return 8'(`ECC_DFLT_TAB >> {6'(a - `ECC_DFLT_BEG), 3'b000});
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  wire idle = mode_reg == MD_IDLE;
  wire is_rd = mode_reg == MD_READ;
  wire is_wr = mode_reg == MD_WRITE;
  wire at_last = addr_reg == `ECC_LAST_ADR;
  wire in_cfg = addr_reg <= `ECC_CFG_END || addr_reg >= `ECC_CFG2_BEG; // RQ2
  wire in_pre = addr_reg >= `ECC_PRE_BEG && addr_reg <= `ECC_PRE_END; // RQ4
  wire cyc_dis = mem[`ECC_CTRL_ADR][`ECC_CYC_DIS];
  wire [7:0] wr_byte = addr_reg == `ECC_C16_LO ? config_checksum_word_reg[7:0] : // RQ6
                       addr_reg == `ECC_C16_HI ? config_checksum_word_reg[15:8] :
                       addr_reg == `ECC_C8_ADR ? preset_checksum_byte_reg : mem[addr_reg];
  wire [7:0] cur_tx = step_reg == ST_DEVW ? `ECC_DEV_WR :
                      step_reg == ST_DEVR ? `ECC_DEV_RD :
                      step_reg == ST_WADR ? 8'(addr_reg) : wr_byte;
  assign cur_op = (step_reg == ST_START || step_reg == ST_RESTART) ? OP_START :
                  step_reg == ST_STOP ? OP_STOP :
                  (step_reg == ST_DATA && is_rd) ? OP_RX : OP_TX;

  // Bit engine: four quarter phases per bit, clock stretching holds the count
  wire eng_go = !eng_busy_reg && (is_rd || is_wr);
  wire hold = (ph_reg == PH_B || ph_reg == PH_C) && !scl_drv_reg && !scl_in;
  wire qtick = eng_busy_reg && !hold && qcnt_reg == 32'(QTR_CYCLES - 1);
  wire is_bit = op_reg == OP_TX || op_reg == OP_RX;
  wire sample = qtick && ph_reg == PH_C && is_bit;
  // Lost arbitration or missing acknowledge both abort the transfer
  wire lost = sample && op_reg == OP_TX &&
              (bit_reg == `ECC_ACK_BIT ? sda_in : (sh_reg[8] && !sda_in)); // RQ1
  wire eng_done = qtick && ph_reg == PH_D && (!is_bit || bit_reg == `ECC_ACK_BIT);
  wire scl_lvl = op_reg == OP_START ? ph_reg <= PH_B :
                 op_reg == OP_STOP ? ph_reg >= PH_B : (ph_reg == PH_B || ph_reg == PH_C);
  wire sda_lvl = op_reg == OP_START ? ph_reg == PH_A :
                 op_reg == OP_STOP ? ph_reg >= PH_C : sh_reg[8];

  // Checksum datapath
  wire rx_done = eng_done && is_rd && step_reg == ST_DATA;
  wire feed = rx_done || mode_reg == MD_CALC;
  wire [7:0] feed_b = is_rd ? sh_reg[8:1] : mem[addr_reg];
  wire [15:0] c16_nx = config_checksum_word_byte(config_checksum_word_reg, feed_b);
  wire [7:0] c8_nx = preset_checksum_byte_byte(preset_checksum_byte_reg, feed_b);
  wire end_bad = c16_nx != stored16_reg || preset_checksum_byte_reg != stored8_reg; // RQ14
  wire txn_end = eng_done && step_reg == ST_STOP;
  wire rd_bad = fail_reg || bad_reg;
  wire final_try = !startup_reg || tries_reg == `ECC_LAST_TRY;
  wire set_crc_err = txn_end && is_rd && bad_reg && !fail_reg && final_try; // RQ11
  wire set_eep_err = txn_end && fail_reg && (is_wr || final_try);
  wire retry = txn_end && is_rd && startup_reg && rd_bad && !final_try; // RQ12
  wire to_dflt = txn_end && is_rd && startup_reg && rd_bad && final_try; // RQ12
  wire st_ok = txn_end && is_rd && startup_reg && !rd_bad;
  wire cyc_hit = cyc_reg == 32'(CYCLE_PERIOD - 1);
  wire start_rd = idle && (pend_reg || (cyc_hit && !cyc_dis)); // RQ9 RQ10
  wire start_wr = idle && !start_rd && write_config_command;
  wire reg_ok = reg_addr <= `ECC_MAP_END && !is_hidden(reg_addr[5:0]); // RQ7
  wire host_we = idle && reg_write && reg_ok;
  wire mem_we = host_we || (rx_done && !verify_reg) || mode_reg == MD_DFLT;
  wire [5:0] mem_wa = host_we ? reg_addr[5:0] : addr_reg;
  wire [7:0] mem_wd = host_we ? reg_wdata : is_rd ? sh_reg[8:1] : dflt_byte(addr_reg, strap_reg);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg <= MD_READ; // RQ8
      step_reg <= ST_START;
      addr_reg <= '0;
      tries_reg <= '0;
      startup_reg <= 1'b1;
      verify_reg <= 1'b0;
      fail_reg <= 1'b0;
      bad_reg <= 1'b0;
      wait_reg <= '0;
    end else begin
      case (mode_reg)
        MD_IDLE: begin
          addr_reg <= '0;
          step_reg <= ST_START;
          fail_reg <= 1'b0;
          bad_reg <= 1'b0;
          verify_reg <= start_rd;
          if (start_rd) begin
            mode_reg <= MD_READ;
          end else if (start_wr) begin
            mode_reg <= MD_CALC; // RQ6
          end
        end
        MD_CALC: begin
          addr_reg <= 6'(addr_reg + 6'd1);
          if (at_last) begin
            mode_reg <= MD_WRITE;
          end
        end
        MD_READ, MD_WRITE: begin
          if (eng_done) begin
            case (step_reg)
              ST_WADR: step_reg <= is_rd ? ST_RESTART : ST_DATA;
              ST_DATA: begin
                if (is_wr || at_last) begin
                  step_reg <= ST_STOP;
                  bad_reg <= is_rd && end_bad;
                end else begin
                  addr_reg <= 6'(addr_reg + 6'd1);
                end
              end
              ST_STOP: begin
                if (is_wr) begin
                  mode_reg <= fail_reg ? MD_IDLE : MD_WAIT;
                  wait_reg <= '0;
                end else if (retry) begin
                  step_reg <= ST_START;
                  addr_reg <= '0;
                  tries_reg <= 2'(tries_reg + 2'd1);
                  fail_reg <= 1'b0;
                  bad_reg <= 1'b0;
                end else if (to_dflt) begin
                  mode_reg <= MD_DFLT;
                  addr_reg <= '0;
                end else begin
                  mode_reg <= MD_IDLE;
                  startup_reg <= 1'b0;
                end
              end
              default: step_reg <= ecc_step_type'(step_reg + 3'd1);
            endcase
            if (op_err_reg && step_reg != ST_STOP) begin
              step_reg <= ST_STOP; // RQ12
              fail_reg <= 1'b1;
            end
          end
        end
        MD_WAIT: begin
          wait_reg <= 32'(wait_reg + 32'd1);
          if (wait_reg == 32'(WRITE_WAIT_CYCLES - 1)) begin
            mode_reg <= at_last ? MD_IDLE : MD_WRITE;
            addr_reg <= 6'(addr_reg + 6'd1);
            step_reg <= ST_START;
          end
        end
        MD_DFLT: begin
          addr_reg <= 6'(addr_reg + 6'd1);
          if (at_last) begin
            mode_reg <= MD_IDLE;
            startup_reg <= 1'b0;
          end
        end
        default: mode_reg <= MD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      eng_busy_reg <= 1'b0;
      op_reg <= OP_STOP;
      ph_reg <= PH_A;
      bit_reg <= '0;
      sh_reg <= '1;
      qcnt_reg <= '0;
      op_err_reg <= 1'b0;
    end else if (eng_go) begin
      eng_busy_reg <= 1'b1;
      op_reg <= cur_op;
      ph_reg <= PH_A;
      bit_reg <= '0;
      qcnt_reg <= '0;
      op_err_reg <= 1'b0;
      sh_reg <= cur_op == OP_RX ? {8'hFF, at_last} : {cur_tx, 1'b1};
    end else if (eng_busy_reg && !hold) begin
      qcnt_reg <= qtick ? '0 : 32'(qcnt_reg + 32'd1);
      if (lost) begin
        op_err_reg <= 1'b1;
      end
      if (sample) begin
        sh_reg <= {sh_reg[7:0], sda_in};
      end
      if (qtick) begin
        ph_reg <= ecc_phase_type'(ph_reg + 2'd1);
        if (ph_reg == PH_D) begin
          bit_reg <= 4'(bit_reg + 4'd1);
          eng_busy_reg <= !eng_done;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (eng_busy_reg) begin
      scl_drv_reg <= !scl_lvl;
      // Data holds through the falling clock, else it races SCL into a false START or STOP
      sda_drv_reg <= (is_bit && ph_reg == PH_D) ? sda_drv_reg : !sda_lvl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || (!feed && (idle || (is_rd && step_reg != ST_DATA)))) begin
      config_checksum_word_reg <= `ECC_INIT16; // RQ3
      preset_checksum_byte_reg <= `ECC_INIT8; // RQ5
    end else if (feed) begin
      config_checksum_word_reg <= in_cfg ? c16_nx : config_checksum_word_reg; // RQ2
      preset_checksum_byte_reg <= in_pre ? c8_nx : preset_checksum_byte_reg; // RQ4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stored16_reg <= '0;
      stored8_reg <= '0;
    end else if (rx_done) begin
      stored16_reg[7:0] <= addr_reg == `ECC_C16_LO ? sh_reg[8:1] : stored16_reg[7:0];
      stored16_reg[15:8] <= addr_reg == `ECC_C16_HI ? sh_reg[8:1] : stored16_reg[15:8];
      stored8_reg <= addr_reg == `ECC_C8_ADR ? sh_reg[8:1] : stored8_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Set beats clear on every sticky flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crc_err_reg <= 1'b0;
      eep_err_reg <= 1'b0;
      pend_reg <= 1'b0;
      cyc_reg <= '0;
      strap_reg <= 1'b0;
      rdata_reg <= '0;
      done_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      crc_err_reg <= set_crc_err || (crc_err_reg && !status_clear); // RQ11
      eep_err_reg <= set_eep_err || (eep_err_reg && !status_clear);
      pend_reg <= verify_checksum_command || (pend_reg && !start_rd); // RQ10
      cyc_reg <= (!idle || cyc_hit) ? '0 : 32'(cyc_reg + 32'd1); // RQ9
      strap_reg <= startup_reg ? mode_strap : strap_reg;
      if (reg_read) begin
        rdata_reg <= (reg_ok && !startup_reg) ? mem[reg_addr[5:0]] : '0; // RQ7
      end
      done_reg <= !startup_reg;
      conv_reg <= conv_reg || (st_ok && !crc_err_reg && !eep_err_reg && !multiturn_error); // RQ13
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drv_reg;
  assign sda_oe = sda_drv_reg;
  assign reg_rdata = rdata_reg;
  assign busy = !idle;
  assign checksum_error = crc_err_reg;
  assign eeprom_error = eep_err_reg;
  assign startup_done = done_reg;
  assign converter_enable = conv_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_ARB_ABORT: assert property (lost |=> op_err_reg) // RQ1
    else $error("Bus error not latched");
  AST_CONFIG_CHECKSUM_WORD_SKIP: assert property (mode_reg == MD_CALC && in_pre |=> $stable(config_checksum_word_reg)) // RQ2
    else $error("Preset byte entered config checksum");
  AST_PRESET_CHECKSUM_BYTE_WRITE: assert property (is_wr && step_reg == ST_DATA && addr_reg == `ECC_C8_ADR |-> cur_tx == preset_checksum_byte_reg) // RQ6
    else $error("Preset checksum not written");
  AST_HIDDEN: assert property (reg_read && reg_addr == {2'b00, `ECC_C16_LO} |=> reg_rdata == '0) // RQ7
    else $error("Checksum byte readable");
  AST_STARTUP: assert property ($past(reset) |-> mode_reg == MD_READ && startup_reg) // RQ8
    else $error("No startup check");
  AST_CYC_OFF: assert property (idle && cyc_hit && cyc_dis && !pend_reg && !write_config_command |=> idle) // RQ9
    else $error("Cyclic check while disabled");
  AST_VERIFY: assert property (idle && pend_reg |=> mode_reg == MD_READ && verify_reg) // RQ10
    else $error("Verify command not served");
  AST_CRC_FLAG: assert property (set_crc_err |=> checksum_error) // RQ11
    else $error("Checksum error not flagged");
  AST_DEFAULTS: assert property (to_dflt |=> mode_reg == MD_DFLT && tries_reg == `ECC_LAST_TRY) // RQ12
    else $error("Defaults not loaded on third failure");
  AST_CONV: assert property ($rose(converter_enable) |-> !checksum_error && !eeprom_error && !$past(multiturn_error)) // RQ13
    else $error("Converter started after error");

endmodule
`default_nettype wire

//--- ecc_regs.svh
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH
`define ECC_CTRL_ADR 6'h0D
`define ECC_CYC_DIS 6
`define ECC_CFG_END 6'h20
`define ECC_C16_LO 6'h21
`define ECC_C16_HI 6'h22
`define ECC_PRE_BEG 6'h23
`define ECC_PRE_END 6'h2E
`define ECC_C8_ADR 6'h2F
`define ECC_CFG2_BEG 6'h30
`define ECC_LAST_ADR 6'h3F
`define ECC_MAP_END 8'h3F
`define ECC_POLY16 16'h1021
`define ECC_POLY8 8'h97
`define ECC_INIT16 16'h0001
`define ECC_INIT8 8'h01
// EEPROM bus address, assumed with all chip selects low
`define ECC_DEV_WR 8'hA0
`define ECC_DEV_RD 8'hA1
`define ECC_LAST_TRY 2'd2
`define ECC_ACK_BIT 4'd8
`define ECC_DFLT_BEG 6'h05
`define ECC_DFLT_END 6'h17
`define ECC_DFLT_STRAP 6'h0B
`define ECC_DFLT_TAB 152'h02_1013_0FFF_00A5_0005_0600_0002_0000_0000_0088
`endif

//--- ecc_pkg.sv
`default_nettype none
package ecc_pkg;
  typedef enum logic [2:0] {MD_IDLE, MD_READ, MD_CALC, MD_WRITE, MD_WAIT, MD_DFLT} ecc_mode_type;
  typedef enum logic [2:0] {
    ST_START, ST_DEVW, ST_WADR, ST_RESTART, ST_DEVR, ST_DATA, ST_STOP
  } ecc_step_type;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_TX, OP_RX} ecc_op_type;
  typedef enum logic [1:0] {PH_A, PH_B, PH_C, PH_D} ecc_phase_type;
endpackage
`default_nettype wire

//--- ecc_eeprom_model.sv
`timescale 1ns/1ns
`default_nettype none
module ecc_eeprom_model (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  // Fault and pace controls
  input wire logic nack,
  input wire logic slow
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act = 1'h0;
  logic tx;
  logic ok;
  logic mack;
  int cnt;
  int ph;
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  always @(negedge sda) if (scl) begin
    act = 1'h1;
    tx = 1'h0;
    // The clock fall that ends START is not a bit boundary
    cnt = -1;
    ph = 0;
  end
  always @(posedge sda) if (scl) act = 1'h0;
  always @(posedge scl) if (act) begin
    if (cnt < 8 && !tx) sh = {sh[6:0], sda};
    if (cnt == 8 && tx) mack = !sda;
  end
  always @(negedge scl) if (act) begin
    // Stretch low so the master must wait on the wire
    if (slow) begin
      scl_oe = 1'h1;
      scl_oe <= #95 1'h0;
    end
    if (cnt == 7) begin
      cnt = 8;
      sda_oe = 1'h0;
      if (!tx) begin
        if (ph == 0) begin
          ok = sh[7:1] == 7'h50 && !nack;
          tx = ok && sh[0];
          mack = 1'h1;
        end
        if (ph == 1 && ok) ptr = sh;
        if (ph >= 2 && ok) begin
          mem[ptr] = sh;
          ptr++;
        end
        ph++;
        sda_oe = ok;
      end
    end else if (cnt == 8) begin
      cnt = 0;
      sda_oe = 1'h0;
      if (tx && mack) begin
        sh = mem[ptr];
        ptr++;
        sda_oe = !sh[7];
      end
    end else begin
      cnt++;
      if (tx) sh = sh << 1;
      sda_oe = tx && !sh[7];
    end
  end
endmodule
`default_nettype wire

//--- tb_eeprom_config_crc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tb_eeprom_config_crc_checker;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic verify = 1'h0;
  logic wr_cmd = 1'h0;
  logic clr = 1'h0;
  logic mt = 1'h0;
  logic strap = 1'h0;
  logic nack = 1'h0;
  logic slow = 1'h0;
  logic hits;
  logic rd1 = 1'h0;
  logic rd2 = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, busy, cerr, eerr, done, conv;
  logic [7:0] img [64];
  logic [7:0] exp_q [$];
  logic [7:0] hit [5] = '{8'h00, 8'h20, 8'h30, 8'h23, 8'h2F};
  logic [7:0] spot [5] = '{8'h21, 8'h22, 8'h2F, 8'h10, 8'h25};
  logic [7:0] dfa [6] = '{8'h05, 8'h0B, 8'h0E, 8'h11, 8'h13, 8'h40};
  logic [7:0] dfv [6] = '{8'h88, 8'h02, 8'h06, 8'hA5, 8'hFF, 8'h00};
  logic [15:0] n_start = 16'h0000;
  logic [31:0] r;
  integer seed = 32'h4216_a513;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  // Open-drain wires with pull-ups
  wire logic scl = !(scl_oe | m_scl_oe);
  wire logic sda = !(sda_oe | m_sda_oe);

  ecc_config_checker #(.QTR_CYCLES(2), .WRITE_WAIT_CYCLES(4), .CYCLE_PERIOD(200)) dut (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(rdata), .verify_checksum_command(verify), .write_config_command(wr_cmd),
    .status_clear(clr), .multiturn_error(mt), .mode_strap(strap), .busy(busy),
    .checksum_error(cerr), .eeprom_error(eerr), .startup_done(done),
    .converter_enable(conv)
  );
  ecc_eeprom_model eep (
    .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .nack(nack), .slow(slow)
  );

  ////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  always @(negedge sda) if (scl) n_start++;
  always @(posedge ref_clk) begin
    rd1 <= reg_read;
    rd2 <= rd1;
    cycles++;
    if (cycles == 100000) begin
      n_fail++;
      test_done();
    end
  end
  // Read data is looked at a cycle late, since it holds until the next read
  always @(negedge ref_clk) if (rd2) check("rdata", rdata, exp_q.pop_front());

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] crc(input logic wide);
    logic [15:0] c;
    logic fb;
    c = 16'h0001;
    for (int i = 0; i < 64; i++) begin
      if (wide ? (i <= 32 || i >= 48) : (i >= 35 && i <= 46)) begin
        for (int b = 7; b >= 0; b--) begin
          fb = (wide ? c[15] : c[7]) ^ img[i][b];
          c = {c[14:0], 1'h0} ^ (fb ? (wide ? 16'h1021 : 16'h0097) : 16'h0000);
        end
      end
    end
    return wide ? c : {8'h00, c[7:0]};
  endfunction
  task automatic seal();
    logic [15:0] c;
    c = crc(1'h1);
    img[33] = c[7:0];
    img[34] = c[15:8];
    c = crc(1'h0);
    img[47] = c[7:0];
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'h1;
    @(negedge ref_clk);
    reg_write = 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'h1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    reg_read = 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic settle(input int lim);
    for (int k = 0; k < lim && (busy !== 1'h0 || done !== 1'h1); k++) @(negedge ref_clk);
    check("idle", {busy, done}, 2'h1);
  endtask
  task automatic kick(input logic [2:0] m);
    @(negedge ref_clk);
    {verify, wr_cmd, clr} = m;
    @(negedge ref_clk);
    {verify, wr_cmd, clr} = 3'h0;
    repeat (3) @(negedge ref_clk);
    settle(30000);
  endtask
  task automatic boot(input logic m, input logic k, input logic bad, input logic [15:0] n,
                      input logic [2:0] fl);
    seal();
    mt = m;
    nack = k;
    slow = k;
    for (int i = 0; i < 64; i++) eep.mem[i] = img[i];
    eep.mem[16] = img[16] ^ {7'h00, bad};
    @(negedge ref_clk);
    reset = 1'h1;
    n_start = 16'h0000;
    repeat (20) @(negedge ref_clk);
    reset = 1'h0;
    settle(40000);
    check("starts", n_start, n);
    check("flags", {cerr, eerr, conv}, fl);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    r = $random(seed);
    strap = r[0];
    dfv[1] = strap ? 8'h00 : 8'h02;
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      img[i] = r[7:0];
    end
    img[13][6] = 1'h1;
    boot(1'h1, 1'h0, 1'h0, 16'h0002, 3'h0);
    boot(1'h0, 1'h0, 1'h0, 16'h0002, 3'h1);
    reg_rd(8'h05, img[5]);
    foreach (hit[i]) begin
      r = $random(seed);
      eep.mem[hit[i]] = img[hit[i]] ^ (8'h01 << r[2:0]);
      kick(3'h4);
      check("crc_err", cerr, 1'h1);
      eep.mem[hit[i]] = img[hit[i]];
      kick(3'h1);
      check("cleared", cerr, 1'h0);
    end
    kick(3'h4);
    check("clean", {cerr, eerr}, 2'h0);
    r = $random(seed);
    img[16] = r[7:0];
    img[37] = r[15:8];
    reg_wr(8'h10, img[16]);
    reg_wr(8'h25, img[37]);
    // Checksum bytes must stay out of reach of the register port
    reg_wr(8'h21, ~img[33]);
    seal();
    kick(3'h2);
    foreach (spot[i]) begin
      check("stored", eep.mem[spot[i]], img[spot[i]]);
      reg_rd(spot[i], i < 3 ? 8'h00 : img[spot[i]]);
    end
    reg_wr(8'h0D, img[13] & 8'hBF);
    eep.mem[48] = ~img[48];
    for (int k = 0; k < 9000 && cerr !== 1'h1; k++) @(negedge ref_clk);
    check("cyclic", cerr, 1'h1);
    settle(30000);
    reg_wr(8'h0D, img[13]);
    kick(3'h1);
    hits = 1'h0;
    repeat (700) begin
      @(negedge ref_clk);
      hits = hits | busy;
    end
    check("no_cyclic", hits, 1'h0);
    boot(1'h0, 1'h0, 1'h1, 16'h0006, 3'h4);
    boot(1'h0, 1'h1, 1'h0, 16'h0003, 3'h2);
    foreach (dfa[i]) reg_rd(dfa[i], dfv[i]);
    repeat (4) @(negedge ref_clk);
    check("pending", exp_q.size(), 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
